// [design/scaler_postproc_pkg.sv]
// Functional notes
// RL1: bit 6 at 2EH picks dither scheme, zero scheme A at reset; bit 7 reserved.
// RL2: software programs all three weights and values before using advanced processing.
// RL3: bits 3..0 at 2FH hold shift amount 0..8, reset to 8.
// RL4: bit 4 at 2FH enables mixing shift, reset disabled.
// RL5: bit 5 at 2FH selects overlay mode, zero dual, one single pixel.
// RL6: bit 6 at 2FH enables overlay swap, effective only in single mode; bit 7 reserved.
// RL7: horizontal offset is 16 bits, high byte 30H, low byte 31H, reset zero.
// RL8: vertical offset is 16 bits, high byte 32H, low byte 33H, reset zero.
// RL9: horizontal reload count 11 bits, 34H bits 2..0 plus 35H, reset zero.
// RL10: vertical reload count 10 bits, 36H bits 1..0 plus 37H, reset zero.
// RL11: overlay mixing weights red, green, blue at 38H, 39H, 3AH, reset zero.
// RL12: processing weights red, green, blue at 3BH, 3CH, 3DH, reset zero.
// RL13: processing red value at 3EH, readable and writable.
// RL14: host writes land only while processor control is on; otherwise core logic writes.
// RL15: reset restores every default; reserved bits read zero and ignore writes.
package scaler_postproc_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] BASE_ADDR = 8'h2E;
    localparam logic [7:0] DITHER_CTRL_ADDR = 8'h2E;
    localparam logic [7:0] POST_CTRL_ADDR = 8'h2F;
    localparam logic [7:0] H_OFS_HI_ADDR = 8'h30;
    localparam logic [7:0] H_OFS_LO_ADDR = 8'h31;
    localparam logic [7:0] V_OFS_HI_ADDR = 8'h32;
    localparam logic [7:0] V_OFS_LO_ADDR = 8'h33;
    localparam logic [7:0] H_RELOAD_HI_ADDR = 8'h34;
    localparam logic [7:0] H_RELOAD_LO_ADDR = 8'h35;
    localparam logic [7:0] V_RELOAD_HI_ADDR = 8'h36;
    localparam logic [7:0] V_RELOAD_LO_ADDR = 8'h37;
    localparam logic [7:0] OSD_R_ADDR = 8'h38;
    localparam logic [7:0] OSD_G_ADDR = 8'h39;
    localparam logic [7:0] OSD_B_ADDR = 8'h3A;
    localparam logic [7:0] PP_R_WEIGHT_ADDR = 8'h3B;
    localparam logic [7:0] PP_G_WEIGHT_ADDR = 8'h3C;
    localparam logic [7:0] PP_B_WEIGHT_ADDR = 8'h3D;
    localparam logic [7:0] PP_R_VALUE_ADDR = 8'h3E;
    localparam int NUM_REGS = 17;
    // ==========================================================
    // field positions
    localparam int DITHER_BIT = 6;
    localparam int MIX_SHIFT_BIT = 4;
    localparam int OSD_MODE_BIT = 5;
    localparam int OSD_SWAP_BIT = 6;
    localparam logic [3:0] SHIFT_MAX = 4'h8;
    // ==========================================================
    // writable masks and reset values
    localparam logic [7:0] DITHER_MASK = 8'h40;
    localparam logic [7:0] POST_CTRL_MASK = 8'h7F;
    localparam logic [7:0] H_RELOAD_HI_MASK = 8'h07;
    localparam logic [7:0] V_RELOAD_HI_MASK = 8'h03;
    localparam logic [7:0] FULL_MASK = 8'hFF;
    localparam logic [7:0] POST_CTRL_RESET = 8'h08;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic ditherSchemeB;
        logic [3:0] shiftAmount;
        logic mixShiftEn;
        logic osdSingle;
        logic osdSwap;
        logic [15:0] hOffset;
        logic [15:0] vOffset;
        logic [10:0] hReload;
        logic [9:0] vReload;
        logic [7:0] osdWeightR;
        logic [7:0] osdWeightG;
        logic [7:0] osdWeightB;
        logic [7:0] ppWeightR;
        logic [7:0] ppWeightG;
        logic [7:0] ppWeightB;
        logic [7:0] ppValueR;
    } cfg_t;
endpackage : scaler_postproc_pkg

// [design/scaler_postproc_config_regs.sv]
`timescale 1ns/1ps
module scaler_postproc_config_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cpuCtrlEnable,
    input wire scaler_postproc_pkg::reg_wr_t hostWr,
    input wire logic [7:0] hostRdAddr,
    output logic [7:0] hostRdData,
    input wire scaler_postproc_pkg::reg_wr_t coreWr,
    output scaler_postproc_pkg::cfg_t cfg
);
    // ==========================================================
    // decode helpers
    function automatic logic inBank(input logic [7:0] addr);
        return addr >= scaler_postproc_pkg::BASE_ADDR && addr <= scaler_postproc_pkg::PP_R_VALUE_ADDR;
    endfunction : inBank

    function automatic logic [4:0] regIndex(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - scaler_postproc_pkg::BASE_ADDR;
        return diff[4:0];
    endfunction : regIndex

    function automatic logic [7:0] writeMask(input logic [7:0] addr);
        case (addr)
            scaler_postproc_pkg::DITHER_CTRL_ADDR: return scaler_postproc_pkg::DITHER_MASK;
            scaler_postproc_pkg::POST_CTRL_ADDR: return scaler_postproc_pkg::POST_CTRL_MASK;
            scaler_postproc_pkg::H_RELOAD_HI_ADDR: return scaler_postproc_pkg::H_RELOAD_HI_MASK;
            scaler_postproc_pkg::V_RELOAD_HI_ADDR: return scaler_postproc_pkg::V_RELOAD_HI_MASK;
            default: return scaler_postproc_pkg::FULL_MASK;
        endcase
    endfunction : writeMask

    function automatic logic [7:0] resetValue(input logic [7:0] addr);
        if (addr == scaler_postproc_pkg::POST_CTRL_ADDR) begin
            return scaler_postproc_pkg::POST_CTRL_RESET;
        end
        return scaler_postproc_pkg::ZERO_RESET;
    endfunction : resetValue

    // out-of-range shift amounts clamp to the largest legal one
    function automatic logic [7:0] legalize(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] v;
        v = data & writeMask(addr);
        if (addr == scaler_postproc_pkg::POST_CTRL_ADDR && v[3:0] > scaler_postproc_pkg::SHIFT_MAX) begin
            v[3:0] = scaler_postproc_pkg::SHIFT_MAX;
        end
        return v;
    endfunction : legalize

    // ==========================================================
    // write arbitration
    scaler_postproc_pkg::reg_wr_t wrSel;
    always_comb begin
        wrSel = cpuCtrlEnable ? hostWr : coreWr; // [RL14]
    end

    // ==========================================================
    // storage
    logic [7:0] bank [0:scaler_postproc_pkg::NUM_REGS-1];
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < scaler_postproc_pkg::NUM_REGS; i++) begin
                bank[i] <= resetValue(scaler_postproc_pkg::BASE_ADDR + 8'(i)); // [RL15]
            end
        end else if (wrSel.write && inBank(wrSel.addr)) begin
            bank[regIndex(wrSel.addr)] <= legalize(wrSel.addr, wrSel.data); // [RL15] [RL3]
        end
    end

    // ==========================================================
    // read port, one cycle after the address
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hostRdData <= 8'h00;
        end else begin
            hostRdData <= inBank(hostRdAddr) ? bank[regIndex(hostRdAddr)] : 8'h00; // [RL13]
        end
    end

    // ==========================================================
    // settings toward the video datapath
    logic [7:0] postCtrl;
    assign postCtrl = bank[1];
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg <= '0;
            cfg.shiftAmount <= scaler_postproc_pkg::POST_CTRL_RESET[3:0];
        end else begin
            cfg.ditherSchemeB <= bank[0][scaler_postproc_pkg::DITHER_BIT]; // [RL1]
            cfg.shiftAmount <= postCtrl[3:0]; // [RL3]
            cfg.mixShiftEn <= postCtrl[scaler_postproc_pkg::MIX_SHIFT_BIT]; // [RL4]
            cfg.osdSingle <= postCtrl[scaler_postproc_pkg::OSD_MODE_BIT]; // [RL5]
            cfg.osdSwap <= postCtrl[scaler_postproc_pkg::OSD_SWAP_BIT]
                & postCtrl[scaler_postproc_pkg::OSD_MODE_BIT]; // [RL6]
            cfg.hOffset <= {bank[2], bank[3]}; // [RL7]
            cfg.vOffset <= {bank[4], bank[5]}; // [RL8]
            cfg.hReload <= {bank[6][2:0], bank[7]}; // [RL9]
            cfg.vReload <= {bank[8][1:0], bank[9]}; // [RL10]
            cfg.osdWeightR <= bank[10]; // [RL11]
            cfg.osdWeightG <= bank[11];
            cfg.osdWeightB <= bank[12];
            cfg.ppWeightR <= bank[13]; // [RL12]
            cfg.ppWeightG <= bank[14];
            cfg.ppWeightB <= bank[15];
            cfg.ppValueR <= bank[16]; // [RL13]
        end
    end

    // ==========================================================
    // flattened copy of the bank for the checks
    logic [8*scaler_postproc_pkg::NUM_REGS-1:0] bankFlat;
    always_comb begin
        for (int i = 0; i < scaler_postproc_pkg::NUM_REGS; i++) begin
            bankFlat[8*i +: 8] = bank[i];
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_dither_select: assert property ( // [RL1]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::DITHER_CTRL_ADDR)
        |-> ##2 cfg.ditherSchemeB == $past(hostWr.data[6], 2))
        else $error("dither scheme bit did not follow write");

    a_shift_legal: assert property ( // [RL3]
        cfg.shiftAmount <= scaler_postproc_pkg::SHIFT_MAX && bank[1][3:0] <= scaler_postproc_pkg::SHIFT_MAX)
        else $error("shift amount above eight");

    a_shift_default: assert property ( // [RL3]
        $past(rst) |-> bank[1] == scaler_postproc_pkg::POST_CTRL_RESET && cfg.shiftAmount == 4'h8)
        else $error("control defaults wrong after reset");

    a_mix_enable: assert property ( // [RL4]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::POST_CTRL_ADDR)
        |-> ##2 cfg.mixShiftEn == $past(hostWr.data[4], 2))
        else $error("mixing shift enable did not follow write");

    a_osd_mode: assert property ( // [RL5]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::POST_CTRL_ADDR)
        |-> ##2 cfg.osdSingle == $past(hostWr.data[5], 2))
        else $error("overlay mode did not follow write");

    a_swap_gated: assert property ( // [RL6]
        cfg.osdSwap |-> cfg.osdSingle && $past(bank[1][6]))
        else $error("overlay swap active outside single mode");

    a_h_offset: assert property ( // [RL7]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::H_OFS_HI_ADDR)
        |-> ##2 cfg.hOffset[15:8] == $past(hostWr.data, 2))
        else $error("horizontal offset high byte wrong");

    a_v_offset: assert property ( // [RL8]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::V_OFS_LO_ADDR)
        |-> ##2 cfg.vOffset[7:0] == $past(hostWr.data, 2))
        else $error("vertical offset low byte wrong");

    a_h_reload_rsv: assert property ( // [RL9]
        bank[6][7:3] == 5'h00 && ($past(rst) ? cfg.hReload == 11'h000
        : cfg.hReload == {$past(bank[6][2:0]), $past(bank[7])}))
        else $error("horizontal reload count malformed");

    a_v_reload_rsv: assert property ( // [RL10]
        bank[8][7:2] == 6'h00 && ($past(rst) ? cfg.vReload == 10'h000
        : cfg.vReload == {$past(bank[8][1:0]), $past(bank[9])}))
        else $error("vertical reload count malformed");

    a_osd_weight: assert property ( // [RL11]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::OSD_B_ADDR)
        |-> ##2 cfg.osdWeightB == $past(hostWr.data, 2))
        else $error("overlay blue weight wrong");

    a_pp_weight: assert property ( // [RL12]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::PP_G_WEIGHT_ADDR)
        |-> ##2 cfg.ppWeightG == $past(hostWr.data, 2))
        else $error("processing green weight wrong");

    a_red_readback: assert property ( // [RL13]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::PP_R_VALUE_ADDR)
        ##1 (hostRdAddr == scaler_postproc_pkg::PP_R_VALUE_ADDR)
        |=> hostRdData == $past(hostWr.data, 2))
        else $error("red value readback wrong");

    a_host_blocked: assert property ( // [RL14]
        (!cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::OSD_R_ADDR
        && !(coreWr.write && coreWr.addr == scaler_postproc_pkg::OSD_R_ADDR))
        |=> $stable(bank[10]))
        else $error("host write landed while processor control off");

    a_core_blocked: assert property ( // [RL14]
        (cpuCtrlEnable && !hostWr.write && coreWr.write && coreWr.addr == scaler_postproc_pkg::OSD_R_ADDR)
        |=> $stable(bank[10]))
        else $error("core write landed while processor control on");

    a_reset_zero: assert property ( // [RL15]
        $past(rst) |-> bank[0] == 8'h00 && bank[2] == 8'h00 && bank[16] == 8'h00 && cfg.hOffset == 16'h0000)
        else $error("registers not cleared by reset");

    a_reserved_zero: assert property ( // [RL15]
        bank[0][7] == 1'b0 && bank[0][5:0] == 6'h00 && bank[1][7] == 1'b0)
        else $error("reserved bits not zero");

    a_h_offset_lo: assert property ( // [RL7]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::H_OFS_LO_ADDR)
        |-> ##2 cfg.hOffset[7:0] == $past(hostWr.data, 2))
        else $error("horizontal offset low byte wrong");

    a_v_offset_hi: assert property ( // [RL8]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::V_OFS_HI_ADDR)
        |-> ##2 cfg.vOffset[15:8] == $past(hostWr.data, 2))
        else $error("vertical offset high byte wrong");

    a_h_reload_lo: assert property ( // [RL9]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::H_RELOAD_LO_ADDR)
        |-> ##2 cfg.hReload[7:0] == $past(hostWr.data, 2))
        else $error("horizontal reload low byte wrong");

    a_v_reload_lo: assert property ( // [RL10]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::V_RELOAD_LO_ADDR)
        |-> ##2 cfg.vReload[7:0] == $past(hostWr.data, 2))
        else $error("vertical reload low byte wrong");

    a_osd_weight_r: assert property ( // [RL11]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::OSD_R_ADDR)
        |-> ##2 cfg.osdWeightR == $past(hostWr.data, 2))
        else $error("overlay red weight wrong");

    a_osd_weight_g: assert property ( // [RL11]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::OSD_G_ADDR)
        |-> ##2 cfg.osdWeightG == $past(hostWr.data, 2))
        else $error("overlay green weight wrong");

    a_pp_weight_r: assert property ( // [RL12]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::PP_R_WEIGHT_ADDR)
        |-> ##2 cfg.ppWeightR == $past(hostWr.data, 2))
        else $error("processing red weight wrong");

    a_pp_weight_b: assert property ( // [RL12]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::PP_B_WEIGHT_ADDR)
        |-> ##2 cfg.ppWeightB == $past(hostWr.data, 2))
        else $error("processing blue weight wrong");

    a_pp_value: assert property ( // [RL13]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::PP_R_VALUE_ADDR)
        |-> ##2 cfg.ppValueR == $past(hostWr.data, 2))
        else $error("processing red value wrong");

    a_dither_mask: assert property ( // [RL1]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::DITHER_CTRL_ADDR)
        |=> bank[0] == ($past(hostWr.data) & scaler_postproc_pkg::DITHER_MASK))
        else $error("dither register kept reserved bits");

    a_h_reload_mask: assert property ( // [RL9]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::H_RELOAD_HI_ADDR)
        |=> bank[6] == ($past(hostWr.data) & scaler_postproc_pkg::H_RELOAD_HI_MASK))
        else $error("horizontal reload high bits not masked");

    a_v_reload_mask: assert property ( // [RL10]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::V_RELOAD_HI_ADDR)
        |=> bank[8] == ($past(hostWr.data) & scaler_postproc_pkg::V_RELOAD_HI_MASK))
        else $error("vertical reload high bits not masked");

    a_shift_clamp: assert property ( // [RL3]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::POST_CTRL_ADDR
        && hostWr.data[3:0] > scaler_postproc_pkg::SHIFT_MAX)
        |-> ##2 cfg.shiftAmount == scaler_postproc_pkg::SHIFT_MAX)
        else $error("oversized shift amount not clamped");

    a_shift_follow: assert property ( // [RL3]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::POST_CTRL_ADDR
        && hostWr.data[3:0] <= scaler_postproc_pkg::SHIFT_MAX)
        |-> ##2 cfg.shiftAmount == $past(hostWr.data[3:0], 2))
        else $error("legal shift amount not kept");

    a_swap_follow: assert property ( // [RL6]
        (cpuCtrlEnable && hostWr.write && hostWr.addr == scaler_postproc_pkg::POST_CTRL_ADDR)
        |-> ##2 cfg.osdSwap == ($past(hostWr.data[6], 2) && $past(hostWr.data[5], 2)))
        else $error("overlay swap not gated by single mode");

    a_host_ignored: assert property ( // [RL14]
        !cpuCtrlEnable && !coreWr.write |=> $stable(bankFlat))
        else $error("bank changed without a core write");

    a_core_ignored: assert property ( // [RL14]
        cpuCtrlEnable && !hostWr.write |=> $stable(bankFlat))
        else $error("bank changed without a host write");

    a_core_lands: assert property ( // [RL14]
        (!cpuCtrlEnable && coreWr.write && coreWr.addr == scaler_postproc_pkg::OSD_R_ADDR)
        |=> bank[10] == $past(coreWr.data))
        else $error("core write to overlay red weight lost");

    a_reset_cfg: assert property ( // [RL15]
        $past(rst) |-> !cfg.ditherSchemeB && !cfg.mixShiftEn && !cfg.osdSingle && !cfg.osdSwap
        && cfg.vOffset == 16'h0000 && cfg.hReload == 11'h000 && cfg.vReload == 10'h000
        && cfg.ppValueR == 8'h00 && hostRdData == 8'h00)
        else $error("settings not at defaults after reset");

    a_read_value: assert property ( // [RL13]
        hostRdAddr == scaler_postproc_pkg::PP_R_VALUE_ADDR |=> hostRdData == $past(bank[16]))
        else $error("red value read port wrong");

endmodule : scaler_postproc_config_regs

// [tb/host_cpu_model.sv]
`timescale 1ns/1ps
// ==========================================================
// host side of the register bus
module host_cpu_model (
    input wire logic ref_clk,
    output scaler_postproc_pkg::reg_wr_t hostWr,
    output logic [7:0] hostRdAddr,
    input wire logic [7:0] hostRdData
);
    initial begin
        hostWr = '0;
        hostRdAddr = 8'h00;
    end
    // one strobe a write, lines scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        hostWr <= '{1'b1, a, d};
        @(posedge ref_clk);
        hostWr <= '{1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        hostRdAddr <= a;
        @(posedge ref_clk);
        #1 d = hostRdData;
    endtask : rd
    // all weights and the value set together before use
    task automatic program_postproc(input logic [7:0] w);
        for (int i = 0; i < 4; i++) wr(8'h3B + 8'(i), w + 8'(i));
    endtask : program_postproc
endmodule : host_cpu_model

// [tb/scaler_postproc_config_regs_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module scaler_postproc_config_regs_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cpuCtrlEnable = 1'b1;
    scaler_postproc_pkg::reg_wr_t hostWr;
    scaler_postproc_pkg::reg_wr_t coreWr = '0;
    logic [7:0] hostRdAddr;
    logic [7:0] hostRdData;
    scaler_postproc_pkg::cfg_t cfg;
    int errors = 0;
    int cmpCount = 0;
    logic [7:0] x;
    always #12.5 ref_clk = ~ref_clk;
    scaler_postproc_config_regs scaler_postproc_config_regs_i (.ref_clk(ref_clk), .rst(rst),
        .cpuCtrlEnable(cpuCtrlEnable), .hostWr(hostWr), .hostRdAddr(hostRdAddr),
        .hostRdData(hostRdData), .coreWr(coreWr), .cfg(cfg));
    host_cpu_model host_cpu_model_i (.ref_clk(ref_clk), .hostWr(hostWr), .hostRdAddr(hostRdAddr),
        .hostRdData(hostRdData));
    // ==========================================================
    // expected contents
    function automatic logic [7:0] stored(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == 8'h2E) ? 8'h40 : (a == 8'h2F) ? 8'h7F : (a == 8'h34) ? 8'h07 : (a == 8'h36) ? 8'h03 : 8'hFF;
        stored = d & m;
        if (a == 8'h2F && d[3:0] > 4'h8) stored[3:0] = 4'h8;
        if (a > 8'h3E || a < 8'h2E) stored = 8'h00;
    endfunction : stored
    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic core_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        coreWr <= '{1'b1, a, d};
        @(posedge ref_clk);
        coreWr <= '{1'b0, ~a, ~d};
    endtask : core_wr
    // ==========================================================
    // scenarios
    task automatic t_reset_values;
        for (int i = 0; i < 18; i++) begin
            host_cpu_model_i.rd(8'h2E + 8'(i), x);
            `CHK("reset read", (i == 1) ? 8'h08 : 8'h00, x)
        end
        `CHK("shift reset", 4'h8, cfg.shiftAmount)
        `CHK("mix reset", 1'b0, cfg.mixShiftEn)
        `CHK("dither reset", 1'b0, cfg.ditherSchemeB)
        `CHK("cfg reset", 0, {cfg.osdSingle, cfg.osdSwap, cfg.hOffset, cfg.vOffset, cfg.hReload, cfg.vReload})
    endtask : t_reset_values
    task automatic t_masks(input logic [7:0] d);
        for (int i = 0; i < 18; i++) begin
            host_cpu_model_i.wr(8'h2E + 8'(i), d);
            host_cpu_model_i.rd(8'h2E + 8'(i), x);
            `CHK("masked readback", stored(8'h2E + 8'(i), d), x)
        end
    endtask : t_masks
    task automatic t_fields;
        for (int i = 0; i < 13; i++) host_cpu_model_i.wr(8'h30 + 8'(i), 8'h41 + 8'(i));
        host_cpu_model_i.program_postproc(8'h4D);
        host_cpu_model_i.rd(8'h3E, x);
        `CHK("value readback", 8'h50, x)
        host_cpu_model_i.wr(8'h3E, 8'h51);
        host_cpu_model_i.rd(8'h3E, x);
        `CHK("value rewrite", 8'h51, x)
        `CHK("h offset", 16'h4142, cfg.hOffset)
        `CHK("v offset", 16'h4344, cfg.vOffset)
        `CHK("h reload", 11'h546, cfg.hReload)
        `CHK("v reload", 10'h348, cfg.vReload)
        `CHK("osd weights", 24'h494A4B, {cfg.osdWeightR, cfg.osdWeightG, cfg.osdWeightB})
        `CHK("pp weights", 24'h4D4E4F, {cfg.ppWeightR, cfg.ppWeightG, cfg.ppWeightB})
        `CHK("pp value", 8'h51, cfg.ppValueR)
    endtask : t_fields
    task automatic t_control;
        for (int m = 0; m < 2; m++) begin
            host_cpu_model_i.wr(8'h2F, {2'b01, 1'(m), 1'b1, 4'h0});
            settle();
            `CHK("osd swap", 1'(m), cfg.osdSwap)
            `CHK("osd single", 1'(m), cfg.osdSingle)
            `CHK("mix shift", 1'b1, cfg.mixShiftEn)
            `CHK("shift zero", 4'h0, cfg.shiftAmount)
            host_cpu_model_i.wr(8'h2E, m ? 8'hBF : 8'h40);
            settle();
            `CHK("dither", 1'(!m), cfg.ditherSchemeB)
        end
    endtask : t_control
    task automatic t_ownership;
        @(posedge ref_clk) cpuCtrlEnable <= 1'b0;
        host_cpu_model_i.wr(8'h38, 8'h11);
        core_wr(8'h38, 8'h22);
        host_cpu_model_i.rd(8'h38, x);
        `CHK("core owns bank", 8'h22, x)
        @(posedge ref_clk) cpuCtrlEnable <= 1'b1;
        core_wr(8'h38, 8'h33);
        host_cpu_model_i.rd(8'h38, x);
        `CHK("host owns bank", 8'h22, x)
        `CHK("osd red weight", 8'h22, cfg.osdWeightR)
    endtask : t_ownership
    task automatic t_midreset;
        host_cpu_model_i.wr(8'h31, 8'h5A);
        @(posedge ref_clk) rst <= 1'b1;
        @(posedge ref_clk) rst <= 1'b0;
        settle();
        `CHK("h offset after reset", 16'h0000, cfg.hOffset)
        `CHK("shift after reset", 4'h8, cfg.shiftAmount)
    endtask : t_midreset
    task automatic print_verdict;
        if (errors == 0 && cmpCount > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset_values();
        t_masks(8'hFF);
        t_masks(8'hA5);
        t_fields();
        t_control();
        t_ownership();
        t_midreset();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end
endmodule : scaler_postproc_config_regs_tb
